// ### logic/lacc_defs.vh
// lacc_defs.vh: constants for the command-list interpreter
// assumes inclusion by bare name from the design files
`ifndef LACC_DEFS_VH
`define LACC_DEFS_VH
// axi register byte offsets
`define LACC_REG_CTRL     8'h00
`define LACC_REG_STATUS   8'h04
`define LACC_REG_CHAIN    8'h08
`define LACC_REG_SCBBASE  8'h0C
`define LACC_REG_CFG0     8'h10
`define LACC_REG_CFG1     8'h14
`define LACC_REG_CFG2     8'h18
`define LACC_REG_CFG3     8'h1C
`define LACC_REG_STADDR0  8'h20
`define LACC_REG_STADDR1  8'h24
// addressing modes
`define LACC_MODE_LEGACY  2'h0
`define LACC_MODE_SEG     2'h1
`define LACC_MODE_LINEAR  2'h2
// command word fields
`define LACC_CW_EL        31
`define LACC_CW_SUSP      30
`define LACC_CW_IRQ       29
`define LACC_CW_CMD_LO    16
`define LACC_CW_CMD_HI    18
`define LACC_CW_RSV_LO    19
`define LACC_CW_RSV_HI    28
`define LACC_CW_DONE      15
`define LACC_CW_BUSY      14
`define LACC_CW_OK        13
`define LACC_CW_LINK_LO   0
`define LACC_CW_LINK_HI   15
`define LACC_CMD_NOP      3'h0
`define LACC_CMD_CONFIG   3'h2
// configure byte count field in parameter word
`define LACC_CNT_MONITOR  4'hC
// configuration reset defaults
`define LACC_DEF_B0       8'h0E
`define LACC_DEF_B1       8'hC8
`define LACC_DEF_B2       8'h40
`define LACC_DEF_B3       8'h26
`define LACC_DEF_B4       8'h00
`define LACC_DEF_B5       8'h60
`define LACC_DEF_B6       8'h00
`define LACC_DEF_B7       8'hF2
`define LACC_DEF_B8       8'h00
`define LACC_DEF_B9       8'h00
`define LACC_DEF_B10      8'h40
`define LACC_DEF_B11      8'hFF
`define LACC_DEF_B12      8'h00
`define LACC_DEF_B13      8'h3F
`define LACC_DEF_B14      8'h00
`define LACC_DEF_B15      8'h00
`define LACC_BCAST_ADDR   48'hFFFF_FFFF_FFFF
// axi responses
`define LACC_RESP_OKAY    2'h0
`define LACC_RESP_SLVERR  2'h2
`endif

// ### logic/lacc_axil_slave.v
// lacc_axil_slave.v: axi4-lite slave front end, one write and one read at a time
// assumes single clock domain, master keeps valid and payload until taken
`timescale 1ns/100ps
`include "lacc_defs.vh"
module lacc_axil_slave (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        wr_stb,
	output wire [7:0]  wr_addr,
	output wire [31:0] wr_data,
	output wire [3:0]  wr_strb,
	input  wire        wr_err,
	output wire [7:0]  rd_addr,
	input  wire [31:0] rd_data,
	input  wire        rd_err
);
	reg        aw_held_q;
	reg        w_held_q;
	reg [7:0]  aw_q;
	reg [31:0] w_q;
	reg [3:0]  ws_q;

	// address and data taken in either order, held until both present
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_stb  = aw_held_q && w_held_q;
	assign wr_addr = aw_q;
	assign wr_data = w_q;
	assign wr_strb = ws_q;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_addr = s_axi_araddr;

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			aw_q         <= 8'h00;
			w_q          <= 32'h0000_0000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LACC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `LACC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_q      <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			// response one cycle after both halves are held
			if (wr_stb) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `LACC_RESP_SLVERR : `LACC_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_err ? `LACC_RESP_SLVERR : `LACC_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // lacc_axil_slave

// ### logic/lacc_top.v
// lacc_top.v: command-list interpreter with memory master port and axi4-lite registers
// assumes memory port answers mem_ack one or more cycles after mem_req, word data
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "lacc_defs.vh"
module lacc_top (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [31:0] mem_addr,
	output reg  [31:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	output reg         command_done_event,
	output wire [47:0] station_address,
	output wire [7:0]  config_byte3,
	output wire [7:0]  config_byte7,
	output wire [7:0]  config_byte8,
	output wire [7:0]  config_byte9,
	output wire [7:0]  config_byte11,
	output wire        keep_bad_frames,
	output wire        two_way_simultaneous,
	output wire        multiple_station_addresses,
	output wire        backoff_disable
);
	// processor states
	localparam ST_IDLE   = 3'h0;
	localparam ST_FETCH  = 3'h1;
	localparam ST_MARK   = 3'h2;
	localparam ST_PARAM  = 3'h3;
	localparam ST_FINISH = 3'h4;
	localparam ST_SUSP   = 3'h5;

	wire        wr_stb;
	wire [7:0]  wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	wire [7:0]  rd_addr;
	reg  [31:0] rd_data;
	reg         rd_err;
	reg         wr_err;

	reg  [2:0]   state_q;
	reg  [1:0]   mode_q;
	reg  [31:0]  chain_q;
	reg  [31:0]  base_q;
	reg  [31:0]  cb_q;
	reg  [31:0]  word0_q;
	reg  [3:0]   pidx_q;
	reg  [4:0]   pcnt_q;
	reg          err_q;
	reg  [7:0]   cfg_q [0:15];
	reg  [47:0]  sta_q;
	reg          running_q;
	reg          suspended_q;
	reg          start_req;
	reg          resume_req;
	integer      k;

	lacc_axil_slave u_axil (
		.clock         (clock),
		.sys_rst       (sys_rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_stb        (wr_stb),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (wr_err),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	// next block address from link field, depends on mode
	function [31:0] link_target;
		input [1:0]  mode;
		input [31:0] base;
		input [31:0] link;
		begin
			if (mode == `LACC_MODE_LINEAR)
				link_target = link;
			else
				link_target = base + {16'h0000, link[`LACC_CW_LINK_HI:`LACC_CW_LINK_LO]};
		end
	endfunction

	// register index of a byte address, unmapped gives all-ones
	function [3:0] reg_index;
		input [7:0] a;
		begin
			if (a[1:0] != 2'h0 || a > `LACC_REG_STADDR1)
				reg_index = 4'hF;
			else
				reg_index = a[5:2];
		end
	endfunction

	assign station_address = sta_q;
	assign config_byte3    = cfg_q[3];
	assign config_byte7    = cfg_q[7];
	assign config_byte8    = cfg_q[8];
	assign config_byte9    = cfg_q[9];
	assign config_byte11   = cfg_q[11];
	assign keep_bad_frames = cfg_q[2][7];
	assign two_way_simultaneous       = cfg_q[12][6];
	assign multiple_station_addresses = cfg_q[13][6];
	assign backoff_disable            = cfg_q[13][7];

	// write decode; ctrl carries mode, start and resume strobes
	always @* begin
		start_req  = 1'b0;
		resume_req = 1'b0;
		wr_err     = 1'b0;
		if (wr_stb) begin
			case (reg_index(wr_addr))
			4'h0: begin
				start_req  = wr_data[0];
				resume_req = wr_data[1];
			end
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9: wr_err = 1'b0;
			default: wr_err = 1'b1;
			endcase
		end
	end

	// read decode, config bytes packed four to a word
	always @* begin
		rd_err  = 1'b0;
		rd_data = 32'h0000_0000;
		case (reg_index(rd_addr))
		4'h0: rd_data = {28'h000_0000, mode_q, 2'h0};
		4'h1: rd_data = {26'h000_0000, err_q, state_q, suspended_q, running_q};
		4'h2: rd_data = chain_q;
		4'h3: rd_data = base_q;
		4'h4: rd_data = {cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
		4'h5: rd_data = {cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]};
		4'h6: rd_data = {cfg_q[11], cfg_q[10], cfg_q[9], cfg_q[8]};
		4'h7: rd_data = {cfg_q[15], cfg_q[14], cfg_q[13], cfg_q[12]};
		4'h8: rd_data = sta_q[31:0];
		4'h9: rd_data = {16'h0000, sta_q[47:32]};
		default: rd_err = 1'b1;
		endcase
	end

	// command processor: fetch, mark busy, run, write done/busy/ok together
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q     <= ST_IDLE;
			mode_q      <= `LACC_MODE_LEGACY;
			chain_q     <= 32'h0000_0000;
			base_q      <= 32'h0000_0000;
			cb_q        <= 32'h0000_0000;
			word0_q     <= 32'h0000_0000;
			pidx_q      <= 4'h0;
			pcnt_q      <= 5'h00;
			err_q       <= 1'b0;
			running_q   <= 1'b0;
			suspended_q <= 1'b0;
			sta_q       <= `LACC_BCAST_ADDR;
			mem_req     <= 1'b0;
			mem_we      <= 1'b0;
			mem_addr    <= 32'h0000_0000;
			mem_wdata   <= 32'h0000_0000;
			command_done_event <= 1'b0;
			// reset defaults of the whole parameter set
			cfg_q[0]  <= `LACC_DEF_B0;
			cfg_q[1]  <= `LACC_DEF_B1;
			cfg_q[2]  <= `LACC_DEF_B2;
			cfg_q[3]  <= `LACC_DEF_B3;
			cfg_q[4]  <= `LACC_DEF_B4;
			cfg_q[5]  <= `LACC_DEF_B5;
			cfg_q[6]  <= `LACC_DEF_B6;
			cfg_q[7]  <= `LACC_DEF_B7;
			cfg_q[8]  <= `LACC_DEF_B8;
			cfg_q[9]  <= `LACC_DEF_B9;
			cfg_q[10] <= `LACC_DEF_B10;
			cfg_q[11] <= `LACC_DEF_B11;
			cfg_q[12] <= `LACC_DEF_B12;
			cfg_q[13] <= `LACC_DEF_B13;
			cfg_q[14] <= `LACC_DEF_B14;
			cfg_q[15] <= `LACC_DEF_B15;
		end else begin
			command_done_event <= 1'b0;
			// register writes; only idle changes mode and chain
			if (wr_stb && state_q == ST_IDLE) begin
				case (reg_index(wr_addr))
				4'h0: mode_q <= (wr_data[3:2] == 2'h3) ? mode_q : wr_data[3:2];
				4'h2: chain_q <= wr_data;
				4'h3: base_q <= wr_data;
				4'h8: sta_q[31:0] <= wr_data;
				4'h9: sta_q[47:32] <= wr_data[15:0];
				default: ;
				endcase
			end
			case (state_q)
			ST_IDLE: begin
				if (start_req) begin
					cb_q      <= chain_q;
					running_q <= 1'b1;
					state_q   <= ST_FETCH;
					mem_req   <= 1'b1;
					mem_we    <= 1'b0;
					mem_addr  <= chain_q;
				end
			end
			ST_FETCH: begin
				if (mem_ack) begin
					word0_q   <= mem_rdata;
					mem_we    <= 1'b1;
					mem_wdata <= {mem_rdata[31:16], 3'h2, mem_rdata[12:0]}; // busy set
					state_q   <= ST_MARK;
				end
			end
			ST_MARK: begin
				if (mem_ack) begin
					err_q  <= 1'b0;
					pidx_q <= 4'h0;
					mem_we <= 1'b0;
					if (mode_q != `LACC_MODE_LEGACY &&
					    word0_q[`LACC_CW_RSV_HI:`LACC_CW_RSV_LO] != 10'h000) begin
						err_q   <= 1'b1; // reserved bits must be zero
						mem_req <= 1'b0;
						state_q <= ST_FINISH;
					end else if (word0_q[`LACC_CW_CMD_HI:`LACC_CW_CMD_LO] == `LACC_CMD_CONFIG) begin
						mem_addr <= cb_q + 32'h0000_0008;
						state_q  <= ST_PARAM;
					end else begin
						// nop and unknown codes do nothing
						mem_req <= 1'b0;
						state_q <= ST_FINISH;
					end
				end
			end
			ST_PARAM: begin
				if (mem_ack) begin
					// first word low bits carry the byte count
					if (pidx_q == 4'h0) begin
						pcnt_q <= {1'b0, mem_rdata[3:0]};
						if (mem_rdata[3:0] > 4'h1)
							cfg_q[1] <= (mem_rdata[3:0] < `LACC_CNT_MONITOR) ?
							            {cfg_q[1][7:6], mem_rdata[13:8]} : mem_rdata[15:8];
						if (mem_rdata[3:0] > 4'h2)
							cfg_q[2] <= mem_rdata[23:16];
						if (mem_rdata[3:0] > 4'h3)
							cfg_q[3] <= mem_rdata[31:24];
					end else begin
						for (k = 0; k < 4; k = k + 1) begin
							if ({1'b0, pidx_q} * 5'h04 + k[4:0] < pcnt_q) begin
								cfg_q[{pidx_q[1:0], k[1:0]}] <= mem_rdata[k*8 +: 8];
							end
						end
					end
					if (pidx_q == 4'h3 || (pidx_q != 4'h0 && {1'b0, pidx_q} * 5'h04 + 5'h04 >= pcnt_q)
					    || (pidx_q == 4'h0 && mem_rdata[3:0] <= 4'h4)) begin
						mem_req <= 1'b0;
						state_q <= ST_FINISH;
					end else begin
						pidx_q   <= pidx_q + 4'h1;
						mem_addr <= mem_addr + 32'h0000_0004;
					end
				end
			end
			ST_FINISH: begin
				if (!mem_req) begin
					// done, busy clear and ok in one write
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= cb_q;
					mem_wdata <= {word0_q[31:16], 1'b1, 1'b0, !err_q, word0_q[12:0]};
				end else if (mem_ack) begin
					mem_we  <= 1'b0;
					command_done_event <= word0_q[`LACC_CW_IRQ];
					cb_q    <= link_target(mode_q, base_q, mem_rdata_link(word0_q));
					if (word0_q[`LACC_CW_EL]) begin
						mem_req   <= 1'b0;
						running_q <= 1'b0;
						state_q   <= ST_IDLE;
					end else if (word0_q[`LACC_CW_SUSP]) begin
						// prefetch the next block's word before suspending
						mem_addr <= link_target(mode_q, base_q, mem_rdata_link(word0_q));
						state_q  <= ST_SUSP;
					end else begin
						mem_addr <= link_target(mode_q, base_q, mem_rdata_link(word0_q));
						state_q  <= ST_FETCH;
					end
				end
			end
			ST_SUSP: begin
				// resume is heard only after the prefetch lands; an earlier strobe is lost
				if (mem_req) begin
					if (mem_ack) begin
						word0_q     <= mem_rdata;
						mem_req     <= 1'b0;
						suspended_q <= 1'b1;
					end
				end else if (resume_req) begin
					suspended_q <= 1'b0;
					mem_req     <= 1'b1;
					mem_we      <= !cfg_q[2][1];
					mem_addr    <= cb_q;
					// without reread the prefetched word goes straight to the busy write
					mem_wdata   <= {word0_q[31:16], 3'h2, word0_q[12:0]};
					state_q     <= cfg_q[2][1] ? ST_FETCH : ST_MARK;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// link offset sits in the low half of the command word
	function [31:0] mem_rdata_link;
		input [31:0] w0;
		begin
			mem_rdata_link = {16'h0000, w0[`LACC_CW_LINK_HI:`LACC_CW_LINK_LO]};
		end
	endfunction
endmodule // lacc_top

// ### tb/lacc_top_asserts.sv
// port checker for the command-list interpreter
// assumes a bind from tb onto lacc_top, one clock domain
`timescale 1ns/100ps
module lacc_checker (
	input logic        clock,
	input logic        sys_rst,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        mem_req,
	input logic        mem_ack,
	input logic        mem_we,
	input logic [31:0] mem_addr,
	input logic [31:0] mem_wdata,
	input logic        command_done_event,
	input logic [47:0] station_address
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic [2:0] since_q;
	// age of the last closing write that asked for an event, saturating
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			since_q <= 3'h7;
		else if (mem_req && mem_ack && mem_we && mem_wdata[15] && mem_wdata[29])
			since_q <= 3'h0;
		else if (since_q != 3'h7)
			since_q <= since_q + 3'h1;
	end
	a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata)) else $error("memory request moved");
	a_done_busy_off: assert property (mem_req && mem_we && mem_wdata[15] |-> !mem_wdata[14])
		else $error("done written with busy");
	a_event_pulse: assert property (command_done_event |=> !command_done_event)
		else $error("event longer than one cycle");
	a_event_cause: assert property ($rose(command_done_event) |-> since_q <= 3'h4)
		else $error("event without irq block");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_write_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_station_reset: assert property (disable iff (1'b0) $past(sys_rst) |-> &station_address)
		else $error("station address not broadcast in reset");
	cover property (command_done_event);
	cover property (mem_ack && mem_we && mem_wdata[15] && !mem_wdata[13]);
	cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
endmodule // lacc_checker

// ### tb/lacc_host_mem.sv
// shared memory model of the host side
// assumes word addresses below 4 kbyte, slow adds three wait cycles
`timescale 1ns/100ps
module lacc_host_mem (
	input  logic        clock,
	input  logic        sys_rst,
	input  logic        slow,
	input  logic        mem_req,
	input  logic        mem_we,
	input  logic [31:0] mem_addr,
	input  logic [31:0] mem_wdata,
	output logic        mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] words [0:1023];
	logic [1:0]  wait_q;
	integer      busy_writes;
	initial begin
		for (int i = 0; i < 1024; i++)
			words[i] = 32'h0000_0000;
	end
	// data is valid only with ack; otherwise it toggles so stale reads show
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mem_ack <= 1'b0;
			wait_q <= 2'h0;
			mem_rdata <= 32'hA5A5_5A5A;
			busy_writes <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				if (slow && wait_q != 2'h3)
					wait_q <= wait_q + 2'h1;
				else begin
					mem_ack <= 1'b1;
					wait_q <= 2'h0;
					mem_rdata <= words[mem_addr[11:2]];
					if (mem_we)
						words[mem_addr[11:2]] <= mem_wdata;
					if (mem_we && mem_wdata[14] && !mem_wdata[15])
						busy_writes <= busy_writes + 1;
				end
			end
		end
	end
endmodule // lacc_host_mem

// ### tb/tb.sv
// self-checking bench for lacc_top with a shared memory model
// assumes the design header is on the include path
`timescale 1ns/100ps
`include "lacc_defs.vh"
module tb;
	logic clock = 1'b0, sys_rst = 1'b1, slow = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire mem_req, mem_we, mem_ack, command_done_event, keep_bad_frames;
	wire two_way_simultaneous, multiple_station_addresses, backoff_disable;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
	wire [47:0] station_address;
	wire [7:0] config_byte3, config_byte7, config_byte8, config_byte9, config_byte11;
	integer mismatches = 0, comparisons = 0, cycles = 0, events = 0;
	logic [31:0] d;
	logic [1:0] r;
	lacc_top DUT (.*);
	lacc_host_mem host (.*);
	always #20 clock = ~clock;
	// cycle ceiling and event counting
	always @(posedge clock) begin
		cycles++;
		if (command_done_event === 1'b1)
			events++;
		if (cycles == 20000) begin
			mismatches++;
			close_out;
		end
	end
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// handshakes judged at the rising edge; an idle edge first keeps strobes single-driven
	task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic pend;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pend = 1'b1;
		while (pend) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				pend = 1'b0;
			end
		end
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic pend;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		pend = 1'b1;
		while (pend) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				v = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				pend = 1'b0;
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		axi_wr(a, v, r);
		check("write response", r, `LACC_RESP_OKAY);
	endtask
	// poll until the block closes and the processor stops or suspends
	task wait_done(input int last);
		int n;
		for (n = 0; n < 200; n++) begin
			axi_rd(`LACC_REG_STATUS, d, r);
			if (host.words[last][15] === 1'b1 && (d[0] === 1'b0 || d[1] === 1'b1))
				break;
		end
		check("chain end", n < 200, 1'b1);
	endtask
	// start the chain and poll until the last block closes
	task run(input logic [1:0] mode, input logic [31:0] chain, input int last);
		wr(`LACC_REG_SCBBASE, 32'h0000_0000);
		wr(`LACC_REG_CHAIN, chain);
		wr(`LACC_REG_CTRL, {28'h000_0000, mode, 2'b01});
		wait_done(last);
	endtask
	task resume(input int last);
		wr(`LACC_REG_CTRL, 32'h0000_0002);
		wait_done(last);
	endtask
	task t_reset;
		check("byte3", config_byte3, 8'h26);
		check("byte7", config_byte7, 8'hF2);
		check("byte8", config_byte8, 8'h00);
		check("byte9", config_byte9, 8'h00);
		check("byte11", config_byte11, 8'hFF);
		check("flags", {keep_bad_frames, two_way_simultaneous, multiple_station_addresses,
			backoff_disable}, 4'h0);
		check("station", station_address, 48'hFFFF_FFFF_FFFF);
		axi_rd(`LACC_REG_CFG0, d, r);
		check("cfg0", d, 32'h2640_C80E);
		axi_rd(`LACC_REG_CFG2, d, r);
		check("cfg2", d, 32'hFF40_0000);
		axi_rd(8'h40, d, r);
		check("unmapped read", {r, d}, {`LACC_RESP_SLVERR, 32'h0000_0000});
		axi_wr(8'h44, 32'h0000_0001, r);
		check("unmapped write", r, `LACC_RESP_SLVERR);
	endtask
	task t_chain;
		int e, b;
		e = events;
		b = host.busy_writes;
		host.words[8] = 32'h0000_0040;
		host.words[16] = 32'hA000_0000;
		run(`LACC_MODE_LEGACY, 32'h0000_0020, 16);
		check("first block", host.words[8], 32'h0000_A040);
		check("last block", host.words[16], 32'hA000_A000);
		check("events", events - e, 1);
		check("busy writes", host.busy_writes - b, 2);
	endtask
	task t_config;
		int e;
		e = events;
		slow <= 1'b1;
		host.words[64] = 32'h8002_0000;
		host.words[66] = 32'h2AC0_050E;
		host.words[67] = 32'hA300_6000;
		host.words[68] = 32'h3C40_5A81;
		host.words[69] = 32'h0000_C040;
		run(`LACC_MODE_LINEAR, 32'h0000_0100, 64);
		check("config block", host.words[64], 32'h8002_A000);
		check("bytes", {config_byte3, config_byte7, config_byte8, config_byte9, config_byte11},
			40'h2AA3_815A_3C);
		check("flags", {keep_bad_frames, two_way_simultaneous, multiple_station_addresses,
			backoff_disable}, 4'hF);
		axi_rd(`LACC_REG_CFG0, d, r);
		check("byte1", d[15:8], 8'h05);
		check("no event", events - e, 0);
		host.words[128] = 32'h8002_0000;
		host.words[130] = 32'h2AC0_C70B;
		run(`LACC_MODE_SEG, 32'h0000_0200, 128);
		axi_rd(`LACC_REG_CFG0, d, r);
		check("monitor kept", d[15:8], 8'h07);
		slow <= 1'b0;
	endtask
	task t_error;
		int e;
		e = events;
		host.words[192] = 32'h8008_0000;
		run(`LACC_MODE_SEG, 32'h0000_0300, 192);
		check("reserved error", host.words[192], 32'h8008_8000);
		host.words[208] = 32'h8007_0000;
		run(`LACC_MODE_SEG, 32'h0000_0340, 208);
		check("unknown done", host.words[208][15:14], 2'b10);
		check("byte3 kept", config_byte3, 8'h2A);
		check("no event", events - e, 0);
	endtask
	// suspend twice: first resume uses the prefetch, second rereads after configure
	task t_suspend;
		host.words[256] = 32'h4000_0480;
		host.words[288] = 32'h4002_04C0;
		host.words[290] = 32'h0002_0503; // reread on
		host.words[304] = 32'h8000_0000;
		run(`LACC_MODE_LEGACY, 32'h0000_0400, 256);
		check("suspended", d[1:0], 2'b11);
		host.words[288] = 32'h4002_04C1;
		resume(288);
		check("prefetch kept", host.words[288], 32'h4002_A4C0);
		host.words[304] = 32'h8000_0001;
		resume(304);
		check("reread", host.words[304], 32'h8000_A001);
		check("stopped", d[1:0], 2'b00);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_reset;
		t_chain;
		t_config;
		t_error;
		t_suspend;
		close_out;
	end
endmodule // tb
bind lacc_top lacc_checker u_chk (.*);
